//--- hw/sbtc_timer16.v
// Three 16-bit timer/counters behind one 8-bit classic Wishbone slave.
// Assumes all inputs synchronous to clk_i; ticks and pins sampled each clock.
//
// How it works
// - Three identical timer instances, each with a true 16-bit counter and PWM.
// - Counter at zero is the bottom condition feeding mode logic.
// - Top comes from fixed maximum, compare A or capture, picked by mode.
// - Compare A as PWM top disables its output; that top is double buffered.
// - Capture register may serve as fixed top, freeing compare A.
// - Both buffered compares checked against counter; match sets its flag.
// - Compare results drive waveform logic on the compare output pins.
// - Tick from prescaler, system clock or external pin edge; none stops it.
// - Capture copies counter on pin or comparator edge, optional spike filter.
// - Four interrupt sources per timer: overflow, compare A, compare B, capture.
// - Flags visible in flag register, each masked by the mask register.
// - Three 8-bit control registers, freely readable and writable.
// - Sixteen-bit registers reached as two byte accesses.
// - One shared high-byte latch per timer.
// - Low-byte write loads latch and new low byte together.
// - Counter or capture low-byte read copies high byte to latch for later high read.
// - Compare high reads come direct and leave the latch alone.
// - Each tick clears, increments or decrements the counter per mode.
// - Bus write to counter beats clear or count in same cycle.
// - Overflow flag set at the point the mode defines.
`timescale 1ns/1ps
`include "sbtc_map.vh"

module sbtc_timer16
(
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [7:0] wb_dat_i,
  input wire wb_sel_i,
  output reg [7:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [2:0] prescale_tick_i,
  input wire [2:0] external_tick_pin_i,
  input wire [2:0] capture_input_pin_i,
  input wire comparator_i,
  input wire [11:0] vector_ack_i,
  output wire [5:0] compare_output_pin_o,
  output wire [2:0] irq_o
);

////////////////////////////////////////////////////////////////////////////////
// Bus decode

// Ack in the take term keeps a held strobe from acting twice
wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wr = acc & wb_we_i & wb_sel_i;
wire rd = acc & ~wb_we_i;
wire [3:0] off = wb_adr_i[3:0];
wire [7:0] rd_bus [0:3];

// Slot three is empty: reads zero, writes fall away
assign rd_bus[3] = `SBTC_RST_BYTE;

// Answer one cycle after the request; the access acts on that same edge
always @(posedge clk_i)
begin
  if (rst_i)
  begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= `SBTC_RST_BYTE;
  end
  else
  begin
    wb_ack_o <= acc;
    wb_dat_o <= rd_bus[wb_adr_i[5:4]];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Timer instances

genvar g;
generate
  for (g = 0; g < 3; g = g + 1)
  begin : tmr
    localparam integer IDX = g;
    reg [7:0] ctrl_a, ctrl_b, ctrl_c;
    reg [7:0] irq_mask_reg;
    // Only one latch per timer, so an interrupted pair access can tear
    reg [7:0] temp_hi;
    reg [3:0] irq_flag_reg;
    reg [15:0] count_value;
    reg [15:0] cmp_a_buf, cmp_b_buf;
    // Active copies are what the counter really meets
    reg [15:0] cmp_a_act, cmp_b_act;
    reg [15:0] capture_value;
    reg dir_down;
    reg ext_q;
    reg cap_raw, cap_filt, cap_prev;
    reg out_a, out_b, irq;
    reg [`SBTC_FILTER_LEN-1:0] cap_hist;
    reg [1:0] kind, top_sel;
    reg tick;
    reg [15:0] next_count;
    reg next_dir;
    reg [7:0] rdata;

    wire me = ({30'h0, wb_adr_i[5:4]} == IDX);
    wire wr_me = wr & me;
    wire rd_me = rd & me;
    wire [3:0] waveform_mode_bits = {ctrl_b[`SBTC_CB_WGM_HI], ctrl_a[`SBTC_CA_WGM_LO]};
    wire [15:0] low_load = {temp_hi, wb_dat_i};
    wire pwm = kind[1];
    wire bottom = (count_value == `SBTC_RST_WORD);
    wire [15:0] top_val = (top_sel == `SBTC_TOP_CMPA) ? cmp_a_act :
      (top_sel == `SBTC_TOP_CAP) ? capture_value : `SBTC_MAX_VAL;
    wire at_top = (count_value == top_val);
    wire ovf_ev = tick & ((kind == `SBTC_KIND_FAST) ? at_top :
      (kind == `SBTC_KIND_PHASE) ? (bottom & dir_down) :
      (count_value == `SBTC_MAX_VAL));
    wire cmpa_ev = tick & (count_value == cmp_a_act);
    wire cmpb_ev = tick & (count_value == cmp_b_act);
    // Capture is frozen while it serves as top, so only a bus write moves the top
    wire cap_edge = ctrl_b[`SBTC_CB_CAP_EDGE] ? (cap_filt & ~cap_prev) : (~cap_filt & cap_prev);
    wire cap_ev = cap_edge & (top_sel != `SBTC_TOP_CAP);
    // Non-PWM kinds use the written value at once; PWM waits for top
    wire upd = ~pwm | (tick & at_top);
    wire [3:0] set_ev = {cap_ev, cmpb_ev, cmpa_ev, ovf_ev};
    wire [3:0] clr_ev = vector_ack_i[4*g+3:4*g] |
      ((wr_me & (off == `SBTC_OFF_FLAGS)) ? wb_dat_i[3:0] : 4'h0);
    wire a_off = pwm & (top_sel == `SBTC_TOP_CMPA);

    assign rd_bus[g] = rdata;
    assign compare_output_pin_o[2*g] = out_a;
    assign compare_output_pin_o[2*g+1] = out_b;
    assign irq_o[g] = irq;

    // Mode decode
    always @*
    begin
      kind = `SBTC_KIND_NORMAL;
      top_sel = `SBTC_TOP_MAX;
      case (waveform_mode_bits)
        4'h1: kind = `SBTC_KIND_PHASE;
        4'h4:
        begin
          kind = `SBTC_KIND_CTC;
          top_sel = `SBTC_TOP_CMPA;
        end
        4'h5: kind = `SBTC_KIND_FAST;
        4'h8:
        begin
          kind = `SBTC_KIND_PHASE;
          top_sel = `SBTC_TOP_CAP;
        end
        4'h9:
        begin
          kind = `SBTC_KIND_PHASE;
          top_sel = `SBTC_TOP_CMPA;
        end
        4'hc:
        begin
          kind = `SBTC_KIND_CTC;
          top_sel = `SBTC_TOP_CAP;
        end
        4'he:
        begin
          kind = `SBTC_KIND_FAST;
          top_sel = `SBTC_TOP_CAP;
        end
        4'hf:
        begin
          kind = `SBTC_KIND_FAST;
          top_sel = `SBTC_TOP_CMPA;
        end
        default: kind = `SBTC_KIND_NORMAL;
      endcase
    end

    // Tick source select
    // Pin edges show in the same cycle the pin differs from the previous sample
    always @*
    begin
      case (ctrl_b[`SBTC_CB_CS])
        `SBTC_CS_STOP: tick = 1'b0;
        `SBTC_CS_SYS: tick = 1'b1;
        `SBTC_CS_EXT_FALL: tick = ext_q & ~external_tick_pin_i[g];
        `SBTC_CS_EXT_RISE: tick = ~ext_q & external_tick_pin_i[g];
        default: tick = prescale_tick_i[g];
      endcase
    end

    // Next count per kind
    always @*
    begin
      next_count = count_value;
      next_dir = dir_down;
      if (tick)
      begin
        case (kind)
          `SBTC_KIND_CTC, `SBTC_KIND_FAST:
            next_count = at_top ? `SBTC_RST_WORD : count_value + 16'h0001;
          `SBTC_KIND_PHASE:
          begin
            if (dir_down ? bottom : ~at_top)
            begin
              next_dir = 1'b0;
              next_count = count_value + 16'h0001;
            end
            else
            begin
              next_dir = 1'b1;
              next_count = count_value - 16'h0001;
            end
          end
          default: next_count = count_value + 16'h0001;
        endcase
      end
    end

    // Read mux; compare high bytes bypass the latch
    always @*
    begin
      case (off)
        `SBTC_OFF_CTRL_A: rdata = ctrl_a;
        `SBTC_OFF_CTRL_B: rdata = ctrl_b;
        `SBTC_OFF_CTRL_C: rdata = ctrl_c;
        `SBTC_OFF_MASK: rdata = irq_mask_reg;
        `SBTC_OFF_FLAGS: rdata = {4'h0, irq_flag_reg};
        `SBTC_OFF_CNT_LO: rdata = count_value[7:0];
        `SBTC_OFF_CNT_HI: rdata = temp_hi;
        `SBTC_OFF_CMPA_LO: rdata = cmp_a_buf[7:0];
        `SBTC_OFF_CMPA_HI: rdata = cmp_a_buf[15:8];
        `SBTC_OFF_CMPB_LO: rdata = cmp_b_buf[7:0];
        `SBTC_OFF_CMPB_HI: rdata = cmp_b_buf[15:8];
        `SBTC_OFF_CAP_LO: rdata = capture_value[7:0];
        `SBTC_OFF_CAP_HI: rdata = temp_hi;
        default: rdata = `SBTC_RST_BYTE;
      endcase
    end

    always @(posedge clk_i)
    begin
      if (rst_i)
      begin
        ctrl_a <= `SBTC_RST_BYTE;
        ctrl_b <= `SBTC_RST_BYTE;
        ctrl_c <= `SBTC_RST_BYTE;
        irq_mask_reg <= `SBTC_RST_BYTE;
        temp_hi <= `SBTC_RST_BYTE;
        irq_flag_reg <= 4'h0;
        count_value <= `SBTC_RST_WORD;
        cmp_a_buf <= `SBTC_RST_WORD;
        cmp_b_buf <= `SBTC_RST_WORD;
        cmp_a_act <= `SBTC_RST_WORD;
        cmp_b_act <= `SBTC_RST_WORD;
        capture_value <= `SBTC_RST_WORD;
        dir_down <= 1'b0;
        ext_q <= 1'b0;
        cap_raw <= 1'b0;
        cap_hist <= {`SBTC_FILTER_LEN{1'b0}};
        cap_filt <= 1'b0;
        cap_prev <= 1'b0;
        out_a <= 1'b0;
        out_b <= 1'b0;
        irq <= 1'b0;
      end
      else
      begin
        ext_q <= external_tick_pin_i[g];
        // Filter trades a few cycles of capture delay for spike rejection
        cap_raw <= ctrl_b[`SBTC_CB_CAP_SRC] ? comparator_i : capture_input_pin_i[g];
        cap_hist <= {cap_hist[`SBTC_FILTER_LEN-2:0], cap_raw};
        if (!ctrl_b[`SBTC_CB_FILTER])
          cap_filt <= cap_raw;
        else if (&cap_hist)
          cap_filt <= 1'b1;
        else if (~|cap_hist)
          cap_filt <= 1'b0;
        cap_prev <= cap_filt;
        if (wr_me && off == `SBTC_OFF_CTRL_A)
          ctrl_a <= wb_dat_i;
        if (wr_me && off == `SBTC_OFF_CTRL_B)
          ctrl_b <= wb_dat_i;
        if (wr_me && off == `SBTC_OFF_CTRL_C)
          ctrl_c <= wb_dat_i;
        if (wr_me && off == `SBTC_OFF_MASK)
          irq_mask_reg <= wb_dat_i;
        // Any high-byte write fills the one shared latch
        if (wr_me && (off == `SBTC_OFF_CNT_HI || off == `SBTC_OFF_CMPA_HI ||
          off == `SBTC_OFF_CMPB_HI || off == `SBTC_OFF_CAP_HI))
          temp_hi <= wb_dat_i;
        else if (rd_me && off == `SBTC_OFF_CNT_LO)
          temp_hi <= count_value[15:8];
        else if (rd_me && off == `SBTC_OFF_CAP_LO)
          temp_hi <= capture_value[15:8];
        if (wr_me && off == `SBTC_OFF_CNT_LO)
          count_value <= low_load;
        else
          count_value <= next_count;
        dir_down <= next_dir;
        if (wr_me && off == `SBTC_OFF_CMPA_LO)
          cmp_a_buf <= low_load;
        if (wr_me && off == `SBTC_OFF_CMPB_LO)
          cmp_b_buf <= low_load;
        if (upd)
        begin
          cmp_a_act <= cmp_a_buf;
          cmp_b_act <= cmp_b_buf;
        end
        if (wr_me && off == `SBTC_OFF_CAP_LO)
          capture_value <= low_load;
        else if (cap_ev)
          capture_value <= count_value;
        // A set in the clearing cycle survives
        irq_flag_reg <= (irq_flag_reg & ~clr_ev) | set_ev;
        // Irq leaves a flop, one clock behind its flag
        irq <= |(irq_flag_reg & irq_mask_reg[3:0]);
        // Match level flips on the down slope for phase-correct
        if (a_off || ctrl_a[`SBTC_CA_COM_A] == 2'h0)
          out_a <= 1'b0;
        else if (ctrl_a[`SBTC_CA_COM_A] == 2'h1)
          out_a <= out_a ^ (cmpa_ev & ~pwm);
        else if (cmpa_ev)
          out_a <= ctrl_a[`SBTC_CA_LVL_A] ^ (kind == `SBTC_KIND_PHASE & dir_down);
        else if (kind == `SBTC_KIND_FAST && tick && at_top)
          out_a <= ~ctrl_a[`SBTC_CA_LVL_A];
        if (ctrl_a[`SBTC_CA_COM_B] == 2'h0)
          out_b <= 1'b0;
        else if (ctrl_a[`SBTC_CA_COM_B] == 2'h1)
          out_b <= out_b ^ (cmpb_ev & ~pwm);
        else if (cmpb_ev)
          out_b <= ctrl_a[`SBTC_CA_LVL_B] ^ (kind == `SBTC_KIND_PHASE & dir_down);
        else if (kind == `SBTC_KIND_FAST && tick && at_top)
          out_b <= ~ctrl_a[`SBTC_CA_LVL_B];
      end
    end
  end
endgenerate

endmodule // sbtc_timer16

//--- hw/sbtc_map.vh
// Constants of the 16-bit timer block: byte offsets, fields, codes.
// Included by the timer core; holds definitions only.
`ifndef SBTC_MAP_VH
`define SBTC_MAP_VH

// Byte offsets inside one timer's 16-byte window
`define SBTC_OFF_CTRL_A 4'h0
`define SBTC_OFF_CTRL_B 4'h1
`define SBTC_OFF_CTRL_C 4'h2
`define SBTC_OFF_MASK 4'h3
`define SBTC_OFF_FLAGS 4'h4
`define SBTC_OFF_CNT_LO 4'h6
`define SBTC_OFF_CNT_HI 4'h7
`define SBTC_OFF_CMPA_LO 4'h8
`define SBTC_OFF_CMPA_HI 4'h9
`define SBTC_OFF_CMPB_LO 4'ha
`define SBTC_OFF_CMPB_HI 4'hb
`define SBTC_OFF_CAP_LO 4'hc
`define SBTC_OFF_CAP_HI 4'hd

// Flag and mask bit positions
`define SBTC_FLAG_OVF 0
`define SBTC_FLAG_CMPA 1
`define SBTC_FLAG_CMPB 2
`define SBTC_FLAG_CAP 3

// Control A fields
`define SBTC_CA_WGM_LO 1:0
`define SBTC_CA_COM_B 5:4
`define SBTC_CA_COM_A 7:6
`define SBTC_CA_LVL_B 4
`define SBTC_CA_LVL_A 6
// Control B fields
`define SBTC_CB_CS 2:0
`define SBTC_CB_WGM_HI 4:3
`define SBTC_CB_CAP_SRC 5
`define SBTC_CB_CAP_EDGE 6
`define SBTC_CB_FILTER 7

// Clock select codes
`define SBTC_CS_STOP 3'h0
`define SBTC_CS_SYS 3'h1
`define SBTC_CS_EXT_FALL 3'h6
`define SBTC_CS_EXT_RISE 3'h7

// Counting kinds and top sources
`define SBTC_KIND_NORMAL 2'h0
`define SBTC_KIND_CTC 2'h1
`define SBTC_KIND_FAST 2'h2
`define SBTC_KIND_PHASE 2'h3
`define SBTC_TOP_MAX 2'h0
`define SBTC_TOP_CMPA 2'h1
`define SBTC_TOP_CAP 2'h2

// Values and counts
`define SBTC_MAX_VAL 16'hffff
`define SBTC_RST_BYTE 8'h00
`define SBTC_RST_WORD 16'h0000
`define SBTC_FILTER_LEN 4

`endif

//--- bench/sbtc_monitor.sv
// Port checker of the three-timer block: bus handshake, reset, holes.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
module sbtc_monitor
(
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [7:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [5:0] compare_output_pin_o,
  input wire [2:0] irq_o
);
  reg [6:0] last_q;
  reg [7:0] last_d;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Last finished transfer, for repeated high-byte reads
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      last_q <= 7'h40;
      last_d <= 8'h00;
    end
    else if (wb_ack_o)
    begin
      last_q <= {wb_we_i, wb_adr_i};
      last_d <= wb_dat_o;
    end
  end
  //////////////////////////////////////////////////////////////////////
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd;
    s_req ##0 !wb_we_i;
  endsequence
  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  property p_unmapped;
    s_rd ##0 (wb_adr_i[5:4] == 2'h3) |=> wb_dat_o == 8'h00;
  endproperty
  property p_hole;
    s_rd ##0 (wb_adr_i[3:0] == 4'h5) |=> wb_dat_o == 8'h00;
  endproperty
  // Latch and compare buffers only move on other accesses
  property p_hi_repeat;
    wb_ack_o && !wb_we_i && wb_adr_i[0] && wb_adr_i[3:0] >= 4'h7 && wb_adr_i[3:0] <= 4'hd
      && last_q == {1'b0, wb_adr_i} |-> wb_dat_o == last_d;
  endproperty
  property p_rst;
    $fell(rst_i) |-> !wb_ack_o && irq_o == 3'h0 && compare_output_pin_o == 6'h00;
  endproperty
  property p_irq_lag;
    $fell(rst_i) |-> ##1 irq_o == 3'h0;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing after request");
  a_ack_once: assert property (p_ack_once)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped timer read not zero");
  a_hole: assert property (p_hole)
    else $error("unused offset read not zero");
  a_hi_repeat: assert property (p_hi_repeat)
    else $error("repeated high byte read changed");
  a_rst: assert property (p_rst)
    else $error("outputs not clear after reset");
  a_irq_lag: assert property (p_irq_lag)
    else $error("irq raised from reset flags");
endmodule // sbtc_monitor
bind sbtc_timer16 sbtc_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .compare_output_pin_o(compare_output_pin_o), .irq_o(irq_o));

//--- bench/sbtc_cpu.sv
// Processor-side model: classic Wishbone byte cycles and 16-bit pairs.
// Assumes a slave that answers with a registered ack.
`timescale 1ns/1ps
module sbtc_cpu
(
  input wire clk_i,
  input wire ack_i,
  input wire [7:0] dat_i,
  output reg cyc_o = 1'b0,
  output reg stb_o = 1'b0,
  output reg we_o = 1'b0,
  output reg sel_o = 1'b1,
  output reg [5:0] adr_o = 6'h00,
  output reg [7:0] dat_o = 8'h00
);
  integer stalls = 0;
  reg [7:0] junk;
  task xfer(input w, input [5:0] a, input [7:0] d, output [7:0] q);
    integer k;
    begin
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= d;
      k = 0;
      @(posedge clk_i);
      while (!ack_i && k < 20)
      begin
        @(posedge clk_i);
        k = k + 1;
      end
      if (!ack_i)
        stalls = stalls + 1;
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      // Released data must not look valid
      dat_o <= ~d;
    end
  endtask
  task wr16(input [5:0] a, input [15:0] v);
    begin
      xfer(1'b1, a + 6'h01, v[15:8], junk);
      xfer(1'b1, a, v[7:0], junk);
    end
  endtask
  task rd16(input [5:0] a, output [15:0] v);
    begin
      xfer(1'b0, a, 8'h00, v[7:0]);
      xfer(1'b0, a + 6'h01, 8'h00, v[15:8]);
    end
  endtask
endmodule // sbtc_cpu

//--- bench/tb.sv
// Self-checking bench of the three-timer block.
// Assumes the processor model and the bound port checker.
`timescale 1ns/1ps
`include "sbtc_map.vh"
module tb;
  localparam [5:0] cnt0 = {2'h0, `SBTC_OFF_CNT_LO};
  localparam [5:0] cnt1 = {2'h1, `SBTC_OFF_CNT_LO};
  localparam [5:0] cb0 = {2'h0, `SBTC_OFF_CTRL_B};
  localparam [5:0] cb1 = {2'h1, `SBTC_OFF_CTRL_B};
  localparam [5:0] flg0 = {2'h0, `SBTC_OFF_FLAGS};
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [2:0] tick = 3'h0;
  reg [2:0] ext = 3'h0;
  reg [2:0] cap = 3'h0;
  reg [11:0] vack = 12'h000;
  reg cmp = 1'b0;
  wire cyc, stb, we, sel, ack;
  wire [5:0] adr, pins;
  wire [7:0] wd, rd8;
  wire [2:0] irq;
  reg [15:0] v;
  reg [7:0] b;
  integer n_fail = 0;
  integer total_checks = 0;
  always #5 clk_i = ~clk_i;
  sbtc_cpu cpu (.clk_i(clk_i), .ack_i(ack), .dat_i(rd8), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wd));
  sbtc_timer16 DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(rd8),
    .wb_ack_o(ack), .prescale_tick_i(tick), .external_tick_pin_i(ext),
    .capture_input_pin_i(cap), .comparator_i(cmp), .vector_ack_i(vack),
    .compare_output_pin_o(pins), .irq_o(irq));
  //////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (e !== g)
      begin
        $display("BAD %s exp %h got %h", nm, e, g);
        n_fail = n_fail + 1;
      end
    end
  endtask
  task wr(input [5:0] a, input [7:0] d);
    cpu.xfer(1'b1, a, d, b);
  endtask
  task rd(input [5:0] a);
    cpu.xfer(1'b0, a, 8'h00, b);
  endtask
  // One tick and one external rising edge per pulse
  task pulse(input [2:0] m, input integer n);
    begin
      repeat (n)
      begin
        @(posedge clk_i);
        tick <= m;
        ext <= m;
        @(posedge clk_i);
        tick <= 3'h0;
        ext <= 3'h0;
      end
      repeat (4) @(posedge clk_i);
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  task s_access;
    begin
      wr(cnt0, 8'h34);
      cpu.rd16(cnt0, v);
      chk("cnt0", 16'h0034, v);
      cpu.wr16(cnt0, 16'h1256);
      cpu.rd16(cnt0, v);
      chk("cnt0", 16'h1256, v);
      cpu.wr16({2'h0, `SBTC_OFF_CMPA_LO}, 16'habcd);
      rd(cnt0);
      rd({2'h0, `SBTC_OFF_CMPA_HI});
      chk("cmpa_hi", 16'h00ab, {8'h00, b});
      rd(cnt0 + 6'h01);
      chk("cnt0_hi", 16'h0012, {8'h00, b});
      rd(cnt0 + 6'h01);
      wr({2'h0, `SBTC_OFF_CMPB_HI}, 8'h77);
      wr(cnt0, 8'h00);
      cpu.rd16(cnt0, v);
      chk("cnt0", 16'h7700, v);
      wr({2'h0, `SBTC_OFF_CTRL_C}, 8'h5a);
      rd({2'h0, `SBTC_OFF_CTRL_C});
      chk("ctrl_c", 16'h005a, {8'h00, b});
      rd({2'h3, `SBTC_OFF_CTRL_C});
      chk("unmapped", 16'h0000, {8'h00, b});
      rd(6'h05);
    end
  endtask
  task s_count;
    begin
      wr(cb1, 8'h02);
      cpu.wr16(cnt1, 16'h00ff);
      pulse(3'h2, 5);
      cpu.rd16(cnt1, v);
      chk("cnt1", 16'h0104, v);
      wr(cb1, {5'h00, `SBTC_CS_EXT_RISE});
      pulse(3'h2, 3);
      cpu.rd16(cnt1, v);
      chk("cnt1", 16'h0107, v);
      wr(cb1, {5'h00, `SBTC_CS_EXT_FALL});
      pulse(3'h2, 2);
      cpu.rd16(cnt1, v);
      chk("cnt1", 16'h0109, v);
      wr(cb1, {5'h00, `SBTC_CS_STOP});
      pulse(3'h2, 4);
      cpu.rd16(cnt1, v);
      chk("cnt1", 16'h0109, v);
    end
  endtask
  task s_flags;
    begin
      wr({2'h0, `SBTC_OFF_MASK}, 8'h02);
      wr(cb0, 8'h02);
      cpu.wr16({2'h0, `SBTC_OFF_CMPA_LO}, 16'h0003);
      cpu.wr16(cnt0, 16'h0001);
      pulse(3'h1, 3);
      rd(flg0);
      chk("flags", 16'h0002, {8'h00, b});
      chk("irq0", 16'h0001, {15'h0000, irq[0]});
      wr(flg0, 8'h02);
      rd(flg0);
      chk("flags", 16'h0000, {8'h00, b});
      chk("irq0", 16'h0000, {15'h0000, irq[0]});
      cpu.wr16(cnt0, 16'hfffe);
      pulse(3'h1, 2);
      rd(flg0);
      chk("flags", 16'h0001, {8'h00, b});
      chk("irq0", 16'h0000, {15'h0000, irq[0]});
      @(posedge clk_i);
      vack <= 12'h001;
      @(posedge clk_i);
      vack <= 12'h000;
      rd(flg0);
      chk("flags", 16'h0000, {8'h00, b});
    end
  endtask
  task s_capture;
    begin
      wr(cb0, 8'h42);
      cpu.wr16(cnt0, 16'h0042);
      @(posedge clk_i);
      cap <= 3'h1;
      repeat (8) @(posedge clk_i);
      cpu.rd16({2'h0, `SBTC_OFF_CAP_LO}, v);
      chk("capture", 16'h0042, v);
      rd(flg0);
      chk("flags", 16'h0008, {8'h00, b});
      // Comparator source through the filter: a short spike must not land
      wr(cb0, 8'he2);
      cpu.wr16(cnt0, 16'h0055);
      @(posedge clk_i);
      cmp <= 1'b1;
      repeat (2) @(posedge clk_i);
      cmp <= 1'b0;
      repeat (8) @(posedge clk_i);
      cpu.rd16({2'h0, `SBTC_OFF_CAP_LO}, v);
      chk("capture", 16'h0042, v);
      cmp <= 1'b1;
      repeat (10) @(posedge clk_i);
      cpu.rd16({2'h0, `SBTC_OFF_CAP_LO}, v);
      chk("capture", 16'h0055, v);
    end
  endtask
  task s_wave;
    begin
      // Timer 2: top from compare A, toggle on match
      cpu.wr16({2'h2, `SBTC_OFF_CMPA_LO}, 16'h0002);
      wr({2'h2, `SBTC_OFF_CTRL_A}, 8'h40);
      wr({2'h2, `SBTC_OFF_CTRL_B}, 8'h0a);
      pulse(3'h4, 3);
      chk("pin_a2", 16'h0001, {15'h0000, pins[4]});
      cpu.rd16({2'h2, `SBTC_OFF_CNT_LO}, v);
      chk("cnt2", 16'h0000, v);
      rd({2'h2, `SBTC_OFF_FLAGS});
      chk("flags2", 16'h0006, {8'h00, b});
      pulse(3'h4, 3);
      chk("pin_a2", 16'h0000, {15'h0000, pins[4]});
      // Fast PWM, top compare A: new top waits for the old top
      wr({2'h2, `SBTC_OFF_CTRL_B}, 8'h18);
      wr({2'h2, `SBTC_OFF_CTRL_A}, 8'he3);
      cpu.wr16({2'h2, `SBTC_OFF_CMPB_LO}, 16'h0001);
      cpu.wr16({2'h2, `SBTC_OFF_CMPA_LO}, 16'h0004);
      wr({2'h2, `SBTC_OFF_CTRL_B}, 8'h1a);
      pulse(3'h4, 3);
      cpu.rd16({2'h2, `SBTC_OFF_CNT_LO}, v);
      chk("cnt2", 16'h0000, v);
      chk("pins2", 16'h0002, {14'h0000, pins[5:4]});
      pulse(3'h4, 2);
      cpu.rd16({2'h2, `SBTC_OFF_CNT_LO}, v);
      chk("cnt2", 16'h0002, v);
      chk("pins2", 16'h0000, {14'h0000, pins[5:4]});
      // Timer 1: phase correct, top from capture, capture pin ignored
      cpu.wr16({2'h1, `SBTC_OFF_CAP_LO}, 16'h0003);
      cpu.wr16(cnt1, 16'h0001);
      wr(cb1, 8'h52);
      cap <= 3'h3;
      pulse(3'h2, 5);
      cpu.rd16(cnt1, v);
      chk("cnt1", 16'h0000, v);
      rd({2'h1, `SBTC_OFF_FLAGS});
      chk("flags1", 16'h0000, {8'h00, b});
      pulse(3'h2, 1);
      rd({2'h1, `SBTC_OFF_FLAGS});
      chk("flags1", 16'h0007, {8'h00, b});
      cpu.rd16({2'h1, `SBTC_OFF_CAP_LO}, v);
      chk("cap1", 16'h0003, v);
    end
  endtask
  task results;
    begin
      n_fail = n_fail + cpu.stalls;
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // A bus that never answers ends the run at once
  always @(posedge clk_i)
    if (cpu.stalls != 0)
      results;
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    s_access;
    s_count;
    s_flags;
    s_capture;
    s_wave;
    results;
  end
endmodule // tb
